// ==== cdt_bist_ext.sv ====
// common-driver test and packet self-test extension register block, wishbone slave
//
// Overview of operation
// - While self-test runs, each errored received nibble adds one to the 8-bit counter in bits 15:8.
// - Restarting a self-test run clears the error counter to zero.
// - The error counter stops at ff and never wraps.
// - With the clock-force bit set both transmit and receive clocks run in any interface mode.
// - In rmii slave mode both mii clocks stay off unless the clock-force bit is set.
// - With the continuous bit set, pseudorandom data is sent with no gaps between packets.
// - Continuous sending only acts while self-test is also enabled in the main phy control register.
// - With pattern enable set the selected common-driver pattern is sent, otherwise none.
// - The internal management data pull-up is on while its enable bit is one.
// - The pull-up enable bit is cleared by hard reset only, not by soft reset.
// - Test sequences are spaced by 15 us when the gap bit is one and 10 us when it is zero.
// - Select 00 sends data with end variant zero, 01 with end variant one, 10 sends link pulses.
// - Select 11 sends constant manchester ones as a 10 MHz tone.
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
module cdt_bist_ext
  import cdt_pkg::*;
(
  input wire logic clk_i, // core clock, 100 MHz
  input wire logic rst_i, // hard reset, synchronous
  input wire logic soft_reset_i, // soft reset pulse
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  input wire logic wb_we_i, // write enable
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  output logic wb_ack_o, // acknowledge
  input wire logic selftest_enable_i, // self-test enabled in main control
  input wire logic selftest_start_i, // self-test run restarted, pulse
  input wire logic nibble_error_i, // errored nibble received, pulse
  input wire logic rmii_slave_mode_i, // interface mode is rmii slave
  input wire logic seq_done_i, // line driver finished a sequence
  output logic tx_clk_en_o, // drive tx clock
  output logic rx_clk_en_o, // drive rx clock
  output logic continuous_tx_o, // gapless pseudorandom transmit
  output logic mgmt_data_pullup_o, // internal pull-up on mdio
  output cdt_pattern_type pattern_o, // common-driver pattern request
  output logic irq_o // interrupt, level
);

  logic [7:0] ctrl_reg;
  logic [7:0] err_cnt_reg;
  logic [2:0] irq_status_reg;
  logic [2:0] irq_mask_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] rd_data;
  logic req;
  logic wr_commit;
  logic wr_ctrl;
  logic err_count;
  logic err_saturate;
  logic seq_end;
  logic [2:0] irq_events;

  assign req = wb_cyc_i && wb_stb_i;
  // writes land on the edge where the master sees ack, never earlier
  assign wr_commit = req && wb_we_i && ack_reg;
  assign wr_ctrl = wr_commit && wb_adr_i == CDT_CTRL_ADDR && wb_sel_i[0];

  always_comb
  begin
    rd_data = '0;
    unique case (wb_adr_i)
      CDT_CTRL_ADDR: rd_data = {16'h0000, err_cnt_reg, ctrl_reg};
      CDT_IRQ_STATUS_ADDR: rd_data = {29'h0, irq_status_reg};
      CDT_IRQ_MASK_ADDR: rd_data = {29'h0, irq_mask_reg};
      default: rd_data = '0;
    endcase
  end

  // one wait state, ack drops the cycle after it was given
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end
    else
    begin
      ack_reg <= req && !ack_reg;
      if (req && !ack_reg)
        dat_reg <= rd_data;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // low byte of control; keeps its value over soft reset, unlike the error counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_reg <= CDT_CTRL_RESET;
    else if (wr_ctrl)
      ctrl_reg <= wb_dat_i[7:0];
  end

  assign err_count = selftest_enable_i && nibble_error_i && err_cnt_reg != CDT_ERRCNT_MAX;
  assign err_saturate = err_count && err_cnt_reg == CDT_ERRCNT_MAX - 8'h01;

  // counter is read only: bus writes never reach it
  always_ff @(posedge clk_i)
  begin
    if (rst_i || soft_reset_i)
      err_cnt_reg <= CDT_ERRCNT_RESET;
    else if (selftest_start_i)
      err_cnt_reg <= CDT_ERRCNT_RESET;
    else if (err_count)
      err_cnt_reg <= err_cnt_reg + 8'h01;
  end

  assign irq_events = {seq_end, err_saturate, err_count};

  // set wins over write-one-to-clear so no event is lost
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_status_reg <= CDT_IRQ_RESET;
      irq_mask_reg <= CDT_IRQ_RESET;
    end
    else
    begin
      if (wr_commit && wb_adr_i == CDT_IRQ_STATUS_ADDR && wb_sel_i[0])
        irq_status_reg <= (irq_status_reg & ~wb_dat_i[2:0]) | irq_events;
      else
        irq_status_reg <= irq_status_reg | irq_events;
      if (wr_commit && wb_adr_i == CDT_IRQ_MASK_ADDR && wb_sel_i[0])
        irq_mask_reg <= wb_dat_i[2:0];
    end
  end

  assign irq_o = |(irq_status_reg & irq_mask_reg);

  assign tx_clk_en_o = ctrl_reg[CDT_CLKFORCE_BIT] || !rmii_slave_mode_i;
  assign rx_clk_en_o = ctrl_reg[CDT_CLKFORCE_BIT] || !rmii_slave_mode_i;
  // gated by the main self-test enable; jabber must already be off in software
  assign continuous_tx_o = ctrl_reg[CDT_CONT_BIT] && selftest_enable_i;
  assign mgmt_data_pullup_o = ctrl_reg[CDT_PULLUP_BIT];

  cdt_pattern_gen u_pattern
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .soft_reset_i(soft_reset_i),
    .enable_i(ctrl_reg[CDT_PATEN_BIT]),
    .sel_i(ctrl_reg[CDT_SEL_LSB +: 2]),
    .gap_long_i(ctrl_reg[CDT_GAP_BIT]),
    .seq_done_i(seq_done_i),
    .pattern_o(pattern_o),
    .seq_end_o(seq_end)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_err_count_step: assert property ((selftest_enable_i && nibble_error_i && !selftest_start_i && !soft_reset_i
    && err_cnt_reg != 8'hff) |=> err_cnt_reg == $past(err_cnt_reg) + 8'h01)
    else $error("error counter did not advance");
  a_err_idle_hold: assert property ((!selftest_enable_i && !selftest_start_i && !soft_reset_i)
    |=> err_cnt_reg == $past(err_cnt_reg))
    else $error("error counter moved outside self-test");
  a_err_restart_clear: assert property (selftest_start_i |=> err_cnt_reg == 8'h00)
    else $error("error counter not cleared on restart");
  a_err_saturate: assert property ((err_cnt_reg == 8'hff && !selftest_start_i && !soft_reset_i)
    |=> err_cnt_reg == 8'hff)
    else $error("error counter wrapped");
  a_clk_force_on: assert property ($rose(ctrl_reg[CDT_CLKFORCE_BIT]) |-> tx_clk_en_o && rx_clk_en_o)
    else $error("clocks not forced on");
  a_rmii_clk_off: assert property ((rmii_slave_mode_i && !ctrl_reg[CDT_CLKFORCE_BIT])
    |-> !tx_clk_en_o && !rx_clk_en_o)
    else $error("clocks running in rmii slave mode");
  a_cont_gated: assert property (!selftest_enable_i |-> !continuous_tx_o)
    else $error("continuous transmit without self-test");
  a_cont_on: assert property ((wr_ctrl && wb_dat_i[CDT_CONT_BIT]) ##1 selftest_enable_i |-> continuous_tx_o)
    else $error("continuous transmit not started");
  a_pullup_soft: assert property ((soft_reset_i && !wr_ctrl) |=> mgmt_data_pullup_o == $past(mgmt_data_pullup_o))
    else $error("pull-up changed by soft reset");
  a_pullup_write: assert property (wr_ctrl |=> mgmt_data_pullup_o == $past(wb_dat_i[CDT_PULLUP_BIT]))
    else $error("pull-up does not follow write");
  a_ctrl_readback: assert property ((req && !ack_reg && !wb_we_i && wb_adr_i == CDT_CTRL_ADDR)
    |=> wb_ack_o && wb_dat_o[15:0] == {$past(err_cnt_reg), $past(ctrl_reg)})
    else $error("control readback wrong");
  a_wb_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for two cycles");

  c_err_saturated: cover property (err_saturate);
  c_cont_tx: cover property (continuous_tx_o);
  c_irq_raised: cover property ($rose(irq_o));

endmodule

// ==== cdt_pattern_gen.sv ====
// common-driver test pattern sequencer with inter-sequence gap timer
`timescale 1ns/1ps
module cdt_pattern_gen
  import cdt_pkg::*;
(
  input wire logic clk_i, // core clock
  input wire logic rst_i, // hard reset
  input wire logic soft_reset_i, // soft reset, restarts sequencer
  input wire logic enable_i, // pattern enable
  input wire logic [1:0] sel_i, // pattern select
  input wire logic gap_long_i, // 1 = long gap
  input wire logic seq_done_i, // line driver finished one sequence
  output cdt_pattern_type pattern_o, // pattern request to line driver
  output logic seq_end_o // one sequence finished
);

  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_GAP} cdt_state_type;

  localparam logic [CDT_GAP_W-1:0] GAP_SHORT_LOAD = CDT_GAP_W'(CDT_GAP_SHORT_CYC - 1);
  localparam logic [CDT_GAP_W-1:0] GAP_LONG_LOAD = CDT_GAP_W'(CDT_GAP_LONG_CYC - 1);

  cdt_state_type state_reg;
  logic [CDT_GAP_W-1:0] gap_reg;
  cdt_pattern_type pattern_reg;
  logic seq_end_reg;

  // tone is continuous, so it never finishes a sequence or enters a gap
  always_ff @(posedge clk_i)
  begin
    if (rst_i || soft_reset_i)
    begin
      state_reg <= ST_IDLE;
      gap_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          if (enable_i)
            state_reg <= ST_SEND;
        end
        ST_SEND:
        begin
          if (!enable_i)
            state_reg <= ST_IDLE;
          else if (sel_i != CDT_SEL_TONE && seq_done_i)
          begin
            state_reg <= ST_GAP;
            gap_reg <= gap_long_i ? GAP_LONG_LOAD : GAP_SHORT_LOAD;
          end
        end
        ST_GAP:
        begin
          if (!enable_i)
            state_reg <= ST_IDLE;
          else if (gap_reg == '0)
            state_reg <= ST_SEND;
          else
            gap_reg <= gap_reg - 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || soft_reset_i)
    begin
      pattern_reg <= '0;
      seq_end_reg <= 1'b0;
    end
    else
    begin
      pattern_reg.active <= enable_i && (state_reg == ST_SEND);
      pattern_reg.kind <= sel_i;
      pattern_reg.start <= enable_i && ((state_reg == ST_IDLE) || (state_reg == ST_GAP && gap_reg == '0));
      seq_end_reg <= enable_i && state_reg == ST_SEND && sel_i != CDT_SEL_TONE && seq_done_i;
    end
  end

  assign pattern_o = pattern_reg;
  assign seq_end_o = seq_end_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || soft_reset_i);

  localparam int LONG_LOAD_I = CDT_GAP_LONG_CYC - 1;
  localparam int SHORT_LOAD_I = CDT_GAP_SHORT_CYC - 1;

  a_gap_long_load: assert property ((state_reg == ST_SEND && enable_i && sel_i != CDT_SEL_TONE && seq_done_i
    && gap_long_i) |=> (state_reg == ST_GAP && int'(gap_reg) == LONG_LOAD_I))
    else $error("long gap not loaded");
  a_gap_short_load: assert property ((state_reg == ST_SEND && enable_i && sel_i != CDT_SEL_TONE && seq_done_i
    && !gap_long_i) |=> (state_reg == ST_GAP && int'(gap_reg) == SHORT_LOAD_I))
    else $error("short gap not loaded");
  a_tone_no_gap: assert property ((state_reg == ST_SEND && enable_i && sel_i == CDT_SEL_TONE)
    |=> state_reg == ST_SEND)
    else $error("tone interrupted by a gap");
  a_disabled_quiet: assert property (!enable_i |=> ##1 !pattern_o.active)
    else $error("pattern sent while disabled");
  a_gap_restart: assert property ((state_reg == ST_GAP && enable_i && gap_reg == '0)
    |=> (state_reg == ST_SEND && pattern_o.start))
    else $error("sequence did not restart after gap");

  c_gap_taken: cover property (state_reg == ST_GAP && gap_reg == '0 && enable_i);
  c_tone_run: cover property (pattern_o.active && pattern_o.kind == CDT_SEL_TONE);

endmodule

// ==== cdt_pkg.sv ====
// package for the common-driver test and self-test extension block
package cdt_pkg;

  // register map, byte addresses on a 32-bit wishbone word bus
  localparam logic [7:0] CDT_CTRL_INDEX = 8'h1b;
  localparam logic [7:0] CDT_CTRL_ADDR = {CDT_CTRL_INDEX[5:0], 2'b00};
  localparam logic [7:0] CDT_IRQ_STATUS_ADDR = 8'h80;
  localparam logic [7:0] CDT_IRQ_MASK_ADDR = 8'h84;

  // control register field positions
  localparam int CDT_ERRCNT_LSB = 8;
  localparam int CDT_RSVD_BIT = 7;
  localparam int CDT_CLKFORCE_BIT = 6;
  localparam int CDT_CONT_BIT = 5;
  localparam int CDT_PATEN_BIT = 4;
  localparam int CDT_PULLUP_BIT = 3;
  localparam int CDT_GAP_BIT = 2;
  localparam int CDT_SEL_LSB = 0;

  // reset values
  localparam logic [7:0] CDT_CTRL_RESET = 8'h00;
  localparam logic [7:0] CDT_ERRCNT_RESET = 8'h00;
  localparam logic [7:0] CDT_ERRCNT_MAX = 8'hff;
  localparam logic [2:0] CDT_IRQ_RESET = 3'h0;

  // interrupt status bits
  localparam int CDT_IRQ_ERR_BIT = 0;
  localparam int CDT_IRQ_SAT_BIT = 1;
  localparam int CDT_IRQ_SEQ_BIT = 2;

  // pattern select codes
  localparam logic [1:0] CDT_SEL_DATA_END_OF_PACKET_VARIANT0 = 2'h0;
  localparam logic [1:0] CDT_SEL_DATA_END_OF_PACKET_VARIANT1 = 2'h1;
  localparam logic [1:0] CDT_SEL_LINK_PULSE = 2'h2;
  localparam logic [1:0] CDT_SEL_TONE = 2'h3;

  // gap timing
  localparam int CDT_CLK_MHZ = 100;
  localparam int CDT_GAP_SHORT_US = 10;
  localparam int CDT_GAP_LONG_US = 15;
  localparam int CDT_GAP_SHORT_CYC = CDT_GAP_SHORT_US * CDT_CLK_MHZ;
  localparam int CDT_GAP_LONG_CYC = CDT_GAP_LONG_US * CDT_CLK_MHZ;
  localparam int CDT_GAP_W = 11;

  typedef struct packed {
    logic active;
    logic [1:0] kind;
    logic start;
  } cdt_pattern_type;

endpackage

// ==== test_cdt_bist_ext.sv ====
// self-checking bench for the common-driver test and self-test extension block
`timescale 1ns/1ps
module test_cdt_bist_ext;
  import cdt_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, soft_reset_i = 1'b0, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [3:0] wb_sel_i = 4'h1;
  logic wb_ack_o, selftest_enable_i = 1'b0, selftest_start_i = 1'b0, nibble_error_i = 1'b0;
  logic rmii_slave_mode_i = 1'b0, seq_done_i = 1'b0;
  logic tx_clk_en_o, rx_clk_en_o, continuous_tx_o, mgmt_data_pullup_o, irq_o;
  cdt_pattern_type pattern_o;
  int fail_count = 0, comparisons = 0, wn;

  cdt_bist_ext i_cdt_bist_ext (.clk_i(clk_i), .rst_i(rst_i), .soft_reset_i(soft_reset_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .selftest_enable_i(selftest_enable_i),
    .selftest_start_i(selftest_start_i), .nibble_error_i(nibble_error_i), .rmii_slave_mode_i(rmii_slave_mode_i),
    .seq_done_i(seq_done_i), .tx_clk_en_o(tx_clk_en_o), .rx_clk_en_o(rx_clk_en_o),
    .continuous_tx_o(continuous_tx_o), .mgmt_data_pullup_o(mgmt_data_pullup_o), .pattern_o(pattern_o),
    .irq_o(irq_o));

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  // entered just after a rising edge; request held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      fail_count++;
      close_out();
    end
    @(posedge clk_i);
  endtask

  task automatic nib(input int k);
    nibble_error_i <= 1'b1;
    tick(k);
    nibble_error_i <= 1'b0;
    tick(2);
  endtask

  task automatic wait_start(input int lim);
    wn = 0;
    do
    begin
      @(posedge clk_i);
      wn++;
    end
    while (pattern_o.start !== 1'b1 && wn < lim);
    if (pattern_o.start !== 1'b1)
    begin
      fail_count++;
      close_out();
    end
  endtask

  task automatic t_reset_regs();
    wb(1'b0, CDT_CTRL_ADDR, 32'h0);
    check(rd, 32'h0);
    check(32'({mgmt_data_pullup_o, continuous_tx_o, pattern_o, irq_o, tx_clk_en_o}), 32'h1);
    wb(1'b1, CDT_CTRL_ADDR, 32'hffff_ffff);
    wb(1'b0, CDT_CTRL_ADDR, 32'h0);
    check(rd, 32'h0000_00ff);
    check(32'(mgmt_data_pullup_o), 32'h1);
    // unmapped place: write dropped, reads zero
    wb(1'b1, 8'h40, 32'h0000_005a);
    wb(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
    // pull-up left off until the soft-reset check in t_count, as on a shared bus
    wb(1'b1, CDT_CTRL_ADDR, 32'h0);
    tick(1);
    check(32'(mgmt_data_pullup_o), 32'h0);
  endtask

  task automatic t_clocks();
    for (int m = 0; m < 4; m++)
    begin
      rmii_slave_mode_i <= m[0];
      wb(1'b1, CDT_CTRL_ADDR, 32'(m[1]) << CDT_CLKFORCE_BIT);
      tick(1);
      check(32'({tx_clk_en_o, rx_clk_en_o}), m[1] | !m[0] ? 32'h3 : 32'h0);
    end
    rmii_slave_mode_i <= 1'b0;
  endtask

  task automatic t_cont();
    // no jabber path in this block; software has it off already
    wb(1'b1, CDT_CTRL_ADDR, 32'h20);
    tick(1);
    check(32'(continuous_tx_o), 32'h0);
    selftest_enable_i <= 1'b1;
    tick(2);
    check(32'(continuous_tx_o), 32'h1);
    wb(1'b1, CDT_CTRL_ADDR, 32'h0);
  endtask

  task automatic t_count();
    nib(3);
    wb(1'b0, CDT_CTRL_ADDR, 32'h0);
    check(32'(rd[15:8]), 32'h3);
    selftest_enable_i <= 1'b0;
    nib(4);
    selftest_enable_i <= 1'b1;
    nib(300);
    wb(1'b0, CDT_CTRL_ADDR, 32'h0);
    check(32'(rd[15:8]), 32'hff);
    wb(1'b0, CDT_IRQ_STATUS_ADDR, 32'h0);
    check(rd, 32'h3);
    selftest_start_i <= 1'b1;
    tick(1);
    selftest_start_i <= 1'b0;
    tick(2);
    wb(1'b0, CDT_CTRL_ADDR, 32'h0);
    check(32'(rd[15:8]), 32'h0);
    // soft reset restarts the counter but must keep the pull-up
    wb(1'b1, CDT_CTRL_ADDR, 32'h08);
    nib(2);
    soft_reset_i <= 1'b1;
    tick(1);
    soft_reset_i <= 1'b0;
    tick(2);
    wb(1'b0, CDT_CTRL_ADDR, 32'h0);
    check(rd, 32'h0000_0008);
  endtask

  task automatic t_irq();
    wb(1'b1, CDT_IRQ_STATUS_ADDR, 32'h7);
    wb(1'b1, CDT_IRQ_MASK_ADDR, 32'h1);
    check(32'(irq_o), 32'h0);
    nib(1);
    check(32'(irq_o), 32'h1);
    wb(1'b1, CDT_IRQ_MASK_ADDR, 32'h0);
    check(32'(irq_o), 32'h0);
    wb(1'b1, CDT_IRQ_STATUS_ADDR, 32'h1);
    wb(1'b0, CDT_IRQ_STATUS_ADDR, 32'h0);
    check(rd, 32'h0);
  endtask

  task automatic t_pattern();
    for (int s = 0; s < 4; s++)
    begin
      wb(1'b1, CDT_CTRL_ADDR, 32'h10 | 32'(s));
      tick(4);
      check(32'({pattern_o.active, pattern_o.kind}), 32'h4 | 32'(s));
    end
    wb(1'b1, CDT_CTRL_ADDR, 32'h0);
    tick(3);
    check(32'(pattern_o.active), 32'h0);
    for (int g = 0; g < 2; g++)
    begin
      wb(1'b1, CDT_CTRL_ADDR, 32'h10 | (32'(g) << CDT_GAP_BIT));
      wait_start(10);
      seq_done_i <= 1'b1;
      tick(1);
      seq_done_i <= 1'b0;
      wait_start(2000);
      // start lands a few cycles after the gap timer expires
      check(32'(wn >= (g ? 1500 : 1000) && wn <= (g ? 1504 : 1004)), 32'h1);
      wb(1'b1, CDT_CTRL_ADDR, 32'h0);
      tick(3);
    end
    wb(1'b0, CDT_IRQ_STATUS_ADDR, 32'h0);
    check(32'(rd[CDT_IRQ_SEQ_BIT]), 32'h1);
  endtask

  initial
  begin
    tick(12);
    rst_i <= 1'b0;
    tick(1);
    t_reset_regs();
    t_clocks();
    t_cont();
    t_count();
    t_irq();
    t_pattern();
    wb(1'b1, CDT_CTRL_ADDR, 32'h08);
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    tick(1);
    check(32'(mgmt_data_pullup_o), 32'h0);
    close_out();
  end
endmodule
